// ---- src/host_adapter_interrupt_reg.sv ----
// host interface interrupt word: host write side and processor side
`timescale 1ns/100ps
module host_adapter_interrupt_reg (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // host direct i/o access
    input  wire logic        host_write,
    input  wire logic [15:0] host_wdata,
    output logic      [15:0] host_rdata,
    // processor side
    input  wire logic        proc_ack,
    input  wire logic        proc_set_host_irq,
    input  wire logic        proc_status_we,
    input  wire logic [6:0]  proc_status,
    input  wire logic        llc_enable,
    input  wire logic        rx_halted,
    input  wire logic        blk_free,
    // outputs
    output logic             host_to_device_irq,
    output logic             host_irq_line,
    output logic             adapter_reset,
    output logic             status_block_free,
    output logic             execute_command,
    output logic             rx_cancel,
    output logic             rx_continue,
    output logic             rx_list_resume,
    output logic             tx_list_resume,
    output logic             command_block_free_request,
    output logic             blk_clear_post
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic       irq_reg;
    logic [6:0] reason_reg;
    logic       host_irq_reg;
    logic [6:0] status_reg;
    logic       blk_wait_reg;
    logic       irq_next;
    logic [6:0] reason_next;
    logic       host_irq_next;
    logic       blk_wait_next;

    wire logic       wr_irq;
    wire logic [6:0] wr_reason;
    wire logic       wr_host_irq_zero;
    wire logic       service;
    wire logic       dec_reset;
    wire logic       dec_stf;
    wire logic       dec_exec;
    wire logic       dec_blk;
    wire logic       dec_cancel;
    wire logic       dec_cont;
    wire logic       dec_rxr;
    wire logic       dec_txr;

    // ------------------------------------------------------------
    // host write decode
    // ------------------------------------------------------------
    assign wr_irq    = host_write & host_wdata[host_irq_pkg::POS_IRQ];
    assign wr_reason = host_write ? host_wdata[host_irq_pkg::POS_RESET:host_irq_pkg::POS_TX_RESUME]
                                  : host_irq_pkg::REASON_RESET;
    assign wr_host_irq_zero = host_write & ~host_wdata[host_irq_pkg::POS_HOST_IRQ];
    // bits 9..15 of host_wdata are never looked at

    // service happens on the processor's acknowledge while pending
    assign service = proc_ack & irq_reg;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // host writes only OR in ones to irq and reason; a set in the ack cycle wins over the clear
    assign irq_next    = wr_irq | (irq_reg & ~proc_ack);
    assign reason_next = wr_reason | (proc_ack ? host_irq_pkg::REASON_RESET
                                               : reason_reg);
    // processor set wins over a host clear in the same cycle
    assign host_irq_next = proc_set_host_irq | (host_irq_reg & ~wr_host_irq_zero);
    assign blk_wait_next = dec_blk | (blk_wait_reg & ~blk_free);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_reg      <= 1'b0;
            reason_reg   <= host_irq_pkg::REASON_RESET;
            host_irq_reg <= 1'b0;
            blk_wait_reg <= 1'b0;
        end else begin
            irq_reg      <= irq_next;
            reason_reg   <= reason_next;
            host_irq_reg <= host_irq_next;
            blk_wait_reg <= blk_wait_next;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= host_irq_pkg::STATUS_RESET;
        end else if (proc_status_we) begin
            status_reg <= proc_status;  // processor-owned bits 9..15
        end
    end

    // ------------------------------------------------------------
    // reason decode at service time
    // ------------------------------------------------------------
    reason_decode u_decode (
        .reason           (reason_reg),
        .service          (service),
        .llc_enable       (llc_enable),
        .rx_halted        (rx_halted),
        .do_adapter_reset (dec_reset),
        .do_status_free   (dec_stf),
        .do_execute       (dec_exec),
        .do_blk_request   (dec_blk),
        .do_rx_cancel     (dec_cancel),
        .do_rx_continue   (dec_cont),
        .do_rx_resume     (dec_rxr),
        .do_tx_resume     (dec_txr)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign host_to_device_irq         = irq_reg;
    assign host_irq_line              = host_irq_reg;
    assign adapter_reset              = dec_reset;
    assign status_block_free          = dec_stf;
    assign execute_command            = dec_exec;
    assign rx_cancel                  = dec_cancel;
    assign rx_continue                = dec_cont;
    assign rx_list_resume             = dec_rxr;
    assign tx_list_resume             = dec_txr;
    assign command_block_free_request = blk_wait_reg;
    // one-cycle request to post the clear code once the block frees
    assign blk_clear_post             = blk_wait_reg & blk_free;

    assign host_rdata = {irq_reg, reason_reg, host_irq_reg, status_reg};
endmodule : host_adapter_interrupt_reg

// ---- src/host_irq_pkg.sv ----
// constants for the host interface interrupt word
package host_irq_pkg;
    // ------------------------------------------------------------
    // bit positions (bit 0 is the most significant bit of the word)
    // ------------------------------------------------------------
    localparam int WORD_W          = 16;
    localparam int POS_IRQ         = 15;  // documented bit 0
    localparam int POS_RESET       = 14;  // bit 1
    localparam int POS_STS_FREE    = 13;  // bit 2
    localparam int POS_EXECUTE     = 12;  // bit 3
    localparam int POS_BLK_REQ     = 11;  // bit 4
    localparam int POS_RX_CANCEL   = 10;  // bit 5
    localparam int POS_RX_RESUME   = 9;   // bit 6
    localparam int POS_TX_RESUME   = 8;   // bit 7
    localparam int POS_HOST_IRQ    = 7;   // bit 8
    localparam int POS_STAT_HI     = 6;   // bits 9..15 occupy [6:0]
    localparam int REASON_W        = 7;
    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [6:0] REASON_RESET  = 7'h00;
    localparam logic [6:0] RESET_PATTERN = 7'h7f;
    localparam logic [6:0] STATUS_RESET  = 7'h00;
    localparam logic [3:0] CODE_BLK_CLEAR = 4'h6;
endpackage : host_irq_pkg

// ---- src/reason_decode.sv ----
// decodes the held reason bits into service strobes
`timescale 1ns/100ps
module reason_decode (
    // held reason and qualifiers
    input  wire logic [6:0] reason,
    input  wire logic       service,
    input  wire logic       llc_enable,
    input  wire logic       rx_halted,
    // service strobes
    output logic            do_adapter_reset,
    output logic            do_status_free,
    output logic            do_execute,
    output logic            do_blk_request,
    output logic            do_rx_cancel,
    output logic            do_rx_continue,
    output logic            do_rx_resume,
    output logic            do_tx_resume
);
    // reason[6] is bit 1, reason[0] is bit 7
    wire logic full_reset;
    assign full_reset       = (reason == host_irq_pkg::RESET_PATTERN);
    assign do_adapter_reset = service & full_reset;
    // a reset pattern carries no other request
    assign do_status_free   = service & ~full_reset & reason[5];
    assign do_execute       = service & ~full_reset & reason[4];
    assign do_blk_request   = service & ~full_reset & reason[3];
    assign do_rx_cancel     = service & ~full_reset & reason[2] & llc_enable
                              & rx_halted;
    assign do_rx_continue   = service & ~full_reset & reason[2] & ~llc_enable;
    assign do_rx_resume     = service & ~full_reset & reason[1];
    assign do_tx_resume     = service & ~full_reset & reason[0];
endmodule : reason_decode

// ---- verif/host_irq_monitor.sv ----
// assertions on the host interface interrupt word
`timescale 1ns/100ps
module host_irq_monitor (
    // watched ports
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        host_write,
    input wire logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata,
    input wire logic        proc_ack,
    input wire logic        proc_set_host_irq,
    input wire logic        host_to_device_irq,
    input wire logic        host_irq_line,
    input wire logic        adapter_reset
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_irq_raise: assert property (host_write && host_wdata[15] |=> host_to_device_irq)
        else $error("irq not raised");
    a_irq_ack: assert property (proc_ack && !host_write |=> !host_to_device_irq)
        else $error("irq not cleared");
    a_irq_hold: assert property (host_to_device_irq && !proc_ack |=> host_to_device_irq)
        else $error("irq dropped");
    a_reason_keep: assert property (!proc_ack |=>
        (host_rdata[14:8] | $past(host_rdata[14:8])) == host_rdata[14:8]) else $error("lost");
    a_reset_dec: assert property (adapter_reset ==
        (proc_ack && host_to_device_irq && &host_rdata[14:8])) else $error("reset decode");
    a_host_clear: assert property (host_write && !host_wdata[7] && !proc_set_host_irq
        |=> !host_irq_line) else $error("line not cleared");
    a_host_set: assert property (proc_set_host_irq |=> host_irq_line)
        else $error("line not set");
    a_read_back: assert property ({host_rdata[15], host_rdata[7]} ==
        {host_to_device_irq, host_irq_line}) else $error("read mismatch");
endmodule : host_irq_monitor
bind host_adapter_interrupt_reg host_irq_monitor mon (.*);

// ---- verif/host_model.sv ----
// behavioural host issuing direct i/o word writes
`timescale 1ns/100ps
module host_model (
    // host bus
    input  wire logic        clock,
    output logic             host_write = 1'b0,
    output logic      [15:0] host_wdata = 16'h0000
);
    task automatic write(input logic [15:0] w);
        @(negedge clock);
        host_write = 1'b1;
        host_wdata = w;
        @(negedge clock);
        host_write = 1'b0;
        host_wdata = ~w; // released bus must not echo the last word
    endtask : write
endmodule : host_model

// ---- verif/tb_host_adapter_interrupt_reg.sv ----
// self-checking bench for the host interface interrupt word
`timescale 1ns/100ps
module tb_host_adapter_interrupt_reg;
    logic        clock = 1'b0, reset_n = 1'b0, proc_ack = 1'b0, proc_set_host_irq = 1'b0;
    logic        proc_status_we = 1'b0, llc_enable = 1'b0, rx_halted = 1'b0, blk_free = 1'b0;
    logic [6:0]  proc_status = 7'h00;
    logic        host_write, host_to_device_irq, host_irq_line, adapter_reset, rx_cancel;
    logic        status_block_free, execute_command, rx_continue, rx_list_resume;
    logic        tx_list_resume, command_block_free_request, blk_clear_post;
    logic [15:0] host_wdata, host_rdata, q[$];
    int          bad_count = 0, tests_run = 0;
    // low two bits carry {llc_enable, rx_halted}; they fall in the ignored field
    logic [15:0] tw [10] = '{16'hff03, 16'hc003, 16'ha003, 16'h9003, 16'h8403, 16'h8402,
                             16'h8400, 16'h8203, 16'h8103, 16'h8803};
    wire  [6:0]  pulse = {adapter_reset, status_block_free, execute_command, rx_cancel,
                          rx_continue, rx_list_resume, tx_list_resume};
    always #50 clock = ~clock;
    host_model host (.clock(clock), .host_write(host_write), .host_wdata(host_wdata));
    host_adapter_interrupt_reg DUT (.*);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) bad_count++;
        if (got !== exp) $display("ERROR %0t: got %h want %h", $time, got, exp);
    endtask : chk
    task automatic svc(input logic [15:0] w, input logic [6:0] r);
        {llc_enable, rx_halted} = w[1:0];
        host.write(w);
        q.push_back({1'b1, r, 1'b0, (&r) ? 7'h40 :
            {1'b0, r[5:4], r[2] & w[1] & w[0], r[2] & ~w[1], r[1:0]}});
        proc_ack = 1'b1;
        @(negedge clock);
        proc_ack = 1'b0;
    endtask : svc
    // pulses only stand in the ack cycle, so they are judged there
    always @(posedge clock)
        if (reset_n && proc_ack && host_to_device_irq === 1'b1)
            chk({host_rdata[15:8], 1'b0, pulse}, q.pop_front());
    initial begin
        void'($urandom(32'hc64b488d));
        repeat (8) @(negedge clock);
        reset_n = 1'b1;
        proc_status = 7'($urandom);
        {proc_set_host_irq, proc_status_we} = 2'h3;
        host.write(16'h00ff);
        {proc_set_host_irq, proc_status_we} = 2'h0;
        chk(host_rdata, {9'h001, proc_status});
        for (int i = 0; i < 10; i++)
            svc(tw[i], tw[i][14:8]);
        chk({14'h0000, command_block_free_request, blk_clear_post}, 16'h0002);
        blk_free = 1'b1;
        #1 chk({14'h0000, command_block_free_request, blk_clear_post}, 16'h0003);
        host.write(16'h9000);
        svc(16'h2003, 7'h30);
        summarize();
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    initial #500000 begin
        bad_count++;
        summarize();
    end
endmodule : tb_host_adapter_interrupt_reg
